// ### include/llw_pkg.sv
// llw_pkg: shared constants for the long-line word handshake
package llw_pkg;
  localparam int CLK_PERIOD_NS   = 10;
  localparam int DESKEW_NS       = 100;
  localparam int DESKEW_LONG_NS  = 200;
  localparam int DATA_DESKEW_LONG_NS = 300;
  localparam int PARITY_NS       = 100;
  localparam int EXTRA_LONG_NS   = 100;
  localparam int READ_REPLY_NS   = 200;
  localparam int READ_REPLY_LONG_NS = 300;
  localparam int SAMPLE_NS       = 100;
  localparam int CONNECT_NS      = 3000;
  // least times round up to whole cycles
  localparam int DESKEW_CYC      = (DESKEW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DESKEW_LONG_CYC = (DESKEW_LONG_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
  localparam int DATA_DESKEW_LONG_CYC = (DATA_DESKEW_LONG_NS + CLK_PERIOD_NS - 1)
                                        / CLK_PERIOD_NS;
  localparam int PARITY_CYC      = (PARITY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int EXTRA_LONG_CYC  = (EXTRA_LONG_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
  localparam int READ_REPLY_CYC  = (READ_REPLY_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
  localparam int READ_REPLY_LONG_CYC = (READ_REPLY_LONG_NS + CLK_PERIOD_NS - 1)
                                       / CLK_PERIOD_NS;
  localparam int SAMPLE_CYC      = (SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONNECT_CYC     = (CONNECT_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
  localparam int DATA_W          = 12;
  localparam int CODE_W          = 12;
  localparam int FIFO_DEPTH      = 16;
  localparam int CNT_W           = 9;
endpackage

// ### include/llw_link_if.sv
// llw_link_if: parallel word link between channel and peripheral
`timescale 1ns/1ps
`default_nettype none
interface llw_link_if;
  logic                        strobe;    // word strobe, channel to device
  logic                        connect;   // select request, channel to device
  logic                        write;     // 1 = channel writes to device
  logic [llw_pkg::DATA_W-1:0]  ch_data;   // data channel to device
  logic                        ch_par;    // odd parity of ch_data
  logic [llw_pkg::DATA_W-1:0]  dev_data;  // data device to channel
  logic                        dev_par;
  logic                        reply;     // acknowledge
  logic                        reject;    // refusal
  modport chan (output strobe, connect, write, ch_data, ch_par,
                input dev_data, dev_par, reply, reject);
  modport dev  (input strobe, connect, write, ch_data, ch_par,
                output dev_data, dev_par, reply, reject);
endinterface
`default_nettype wire

// ### core/llw_fifo.sv
// llw_fifo: flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module llw_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
) (
  input  wire logic             core_clk_i,
  input  wire logic             resetn_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ff;
  logic [AW-1:0]    rd_ff;
  logic [AW:0]      cnt_ff;
  logic             push;
  logic             pop;

  assign in_ready_o  = (cnt_ff != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_ff != '0);
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;
  assign out_data_o  = mem_ff[rd_ff];

  always_ff @(posedge core_clk_i) begin
    if (push) begin
      mem_ff[wr_ff] <= in_data_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) begin
        wr_ff <= (wr_ff == AW'(DEPTH - 1)) ? '0 : wr_ff + 1'b1;
      end
      if (pop) begin
        rd_ff <= (rd_ff == AW'(DEPTH - 1)) ? '0 : rd_ff + 1'b1;
      end
      if (push && !pop) begin
        cnt_ff <= cnt_ff + 1'b1;
      end else if (pop && !push) begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ### core/llw_dev.sv
// llw_dev: peripheral end of the long-line word handshake
`timescale 1ns/1ps
`default_nettype none
// Operation
// - channel waits 100 ns deskew after strobe; llw_chan waits it after reply instead
// - write: delay strobe use for parity check
// - read: hold reply 200 ns after data
// - long cable: control deskew 200 ns
// - long cable: extra 100 ns write strobe delay
// - long cable: read reply delay 300 ns
// - any sample delay at least 100 ns
// - sender drops strobe on reply
// - device drops reply after strobe falls
// - next strobe only after reply falls
// - channel accepts reply after prior fall
// - long line: reply 3 us after connect
// - unmatched unit drops off on connect
// - checked write answered reply or reject
// - receiver checks parity, 100 ns allowed
// - channel samples, drops strobe on reply
// - 12-bit long line: 300 ns data deskew
module llw_dev #(
  parameter int          WIDTH = llw_pkg::DATA_W,
  parameter int          DEPTH = llw_pkg::FIFO_DEPTH,
  parameter logic [11:0] MY_CODE = 12'h001
) (
  input  wire logic             core_clk_i,
  input  wire logic             resetn_i,
  input  wire logic             long_cable_i,
  llw_link_if.dev               link,
  output logic                  selected_o,
  output logic                  rx_valid_o,
  input  wire logic             rx_ready_i,
  output logic      [WIDTH-1:0] rx_data_o,
  input  wire logic             tx_valid_i,
  output logic                  tx_ready_o,
  input  wire logic [WIDTH-1:0] tx_data_i,
  output logic                  par_err_o
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_WAIT = 3'b001,
    ST_ANS  = 3'b010,
    ST_HOLD = 3'b011,
    ST_DROP = 3'b100
  } llw_dst_e;

  llw_dst_e                  st_ff;
  logic [llw_pkg::CNT_W-1:0] cnt_ff;
  logic [WIDTH-1:0]          rx_word_ff;
  logic                      rx_wr_ff;
  logic                      ok_ff;
  logic                      sel_ff;
  logic                      is_conn_ff;
  logic                      rx_in_ready;
  logic                      tx_out_valid;
  logic [WIDTH-1:0]          tx_out_data;
  logic                      tx_pop;
  logic [llw_pkg::CNT_W-1:0] wr_wait;
  logic [llw_pkg::CNT_W-1:0] rd_wait;

  function automatic logic odd_par(input logic [WIDTH-1:0] d);
    odd_par = ~^d;
  endfunction

  // write: deskew + parity + long-line extra; read: reply delay
  assign wr_wait = long_cable_i ?
      llw_pkg::CNT_W'(llw_pkg::DATA_DESKEW_LONG_CYC + llw_pkg::PARITY_CYC
                      + llw_pkg::EXTRA_LONG_CYC) :
      llw_pkg::CNT_W'(llw_pkg::DESKEW_CYC + llw_pkg::PARITY_CYC);
  assign rd_wait = long_cable_i ?
      llw_pkg::CNT_W'(llw_pkg::READ_REPLY_LONG_CYC) :
      llw_pkg::CNT_W'(llw_pkg::READ_REPLY_CYC);

  llw_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_rx_fifo (
    .core_clk_i  (core_clk_i),
    .resetn_i    (resetn_i),
    .in_valid_i  (rx_wr_ff),
    .in_ready_o  (rx_in_ready),
    .in_data_i   (rx_word_ff),
    .out_valid_o (rx_valid_o),
    .out_ready_i (rx_ready_i),
    .out_data_o  (rx_data_o)
  );

  llw_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_tx_fifo (
    .core_clk_i  (core_clk_i),
    .resetn_i    (resetn_i),
    .in_valid_i  (tx_valid_i),
    .in_ready_o  (tx_ready_o),
    .in_data_i   (tx_data_i),
    .out_valid_o (tx_out_valid),
    .out_ready_i (tx_pop),
    .out_data_o  (tx_out_data)
  );

  assign tx_pop     = (st_ff == ST_DROP) && !link.strobe && is_conn_ff == 1'b0
                      && !link.write && ok_ff;
  assign selected_o = sel_ff;

  ////////////////////////////////////////////////////////////////////////////
  // handshake sequencer
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      st_ff      <= ST_IDLE;
      cnt_ff     <= '0;
      is_conn_ff <= 1'b0;
      ok_ff      <= 1'b0;
    end else begin
      case (st_ff)
        ST_IDLE: begin
          cnt_ff <= '0;
          if (link.strobe && link.connect) begin
            is_conn_ff <= 1'b1;
            st_ff      <= ST_WAIT;
          end else if (link.strobe && sel_ff) begin
            is_conn_ff <= 1'b0;
            st_ff      <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          cnt_ff <= cnt_ff + 1'b1;
          if (is_conn_ff) begin
            if (link.ch_data != MY_CODE) begin
              st_ff <= ST_DROP;
            end else if (cnt_ff >= llw_pkg::CNT_W'(llw_pkg::CONNECT_CYC - 1)) begin
              st_ff <= ST_ANS;
            end
          end else if (link.write) begin
            if (cnt_ff >= wr_wait - 1'b1 && rx_in_ready) begin
              st_ff <= ST_ANS;
            end
          end else if (!tx_out_valid) begin
            cnt_ff <= '0;
          end else if (cnt_ff >= rd_wait - 1'b1) begin
            st_ff <= ST_ANS;
          end
        end
        ST_ANS: begin
          ok_ff <= is_conn_ff || !link.write ||
                   (odd_par(link.ch_data) == link.ch_par);
          st_ff <= ST_HOLD;
        end
        ST_HOLD: begin
          if (!link.strobe) begin
            st_ff <= ST_DROP;
          end
        end
        default: begin
          if (!link.strobe) begin
            st_ff <= ST_IDLE;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // select latch, received word capture, answer lines
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      sel_ff <= 1'b0;
    end else if (st_ff == ST_WAIT && is_conn_ff) begin
      sel_ff <= (link.ch_data == MY_CODE);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      rx_word_ff <= '0;
      rx_wr_ff   <= 1'b0;
    end else begin
      rx_wr_ff <= (st_ff == ST_ANS) && !is_conn_ff && link.write &&
                  (odd_par(link.ch_data) == link.ch_par);
      if (st_ff == ST_ANS) begin
        rx_word_ff <= link.ch_data;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      link.reply    <= 1'b0;
      link.reject   <= 1'b0;
      link.dev_data <= '0;
      link.dev_par  <= 1'b0;
      par_err_o     <= 1'b0;
    end else begin
      par_err_o <= (st_ff == ST_ANS) && !is_conn_ff && link.write &&
                   (odd_par(link.ch_data) != link.ch_par);
      if ((st_ff == ST_IDLE || st_ff == ST_WAIT) && tx_out_valid) begin
        link.dev_data <= tx_out_data;
        link.dev_par  <= odd_par(tx_out_data);
      end
      if (st_ff == ST_ANS) begin
        link.reply  <= is_conn_ff || !link.write ||
                       (odd_par(link.ch_data) == link.ch_par);
        link.reject <= !is_conn_ff && link.write &&
                       (odd_par(link.ch_data) != link.ch_par);
      end else if (st_ff == ST_HOLD && !link.strobe) begin
        link.reply  <= 1'b0;
        link.reject <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ### core/llw_chan.sv
// llw_chan: data channel end of the long-line word handshake
`timescale 1ns/1ps
`default_nettype none
module llw_chan #(
  parameter int WIDTH = llw_pkg::DATA_W
) (
  input  wire logic             core_clk_i,
  input  wire logic             resetn_i,
  input  wire logic             long_cable_i,
  llw_link_if.chan              link,
  input  wire logic             req_valid_i,
  output logic                  req_ready_o,
  input  wire logic             req_write_i,
  input  wire logic             req_connect_i,
  input  wire logic [WIDTH-1:0] req_data_i,
  output logic                  done_o,
  output logic                  done_reject_o,
  output logic      [WIDTH-1:0] rd_data_o,
  output logic                  rd_par_err_o
);
  typedef enum logic [2:0] {
    CS_IDLE   = 3'b000,
    CS_WAIT   = 3'b001,
    CS_DESKEW = 3'b010,
    CS_SAMPLE = 3'b011,
    CS_FALL   = 3'b100
  } llw_cst_e;

  llw_cst_e                  st_ff;
  logic [llw_pkg::CNT_W-1:0] cnt_ff;
  logic                      rej_ff;
  logic [llw_pkg::CNT_W-1:0] dsk;

  assign dsk = long_cable_i ? llw_pkg::CNT_W'(llw_pkg::DESKEW_LONG_CYC)
                            : llw_pkg::CNT_W'(llw_pkg::DESKEW_CYC);
  assign req_ready_o = (st_ff == CS_IDLE) && !link.reply && !link.reject;

  ////////////////////////////////////////////////////////////////////////////
  // channel sequencer
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      st_ff        <= CS_IDLE;
      cnt_ff       <= '0;
      rej_ff       <= 1'b0;
      link.strobe  <= 1'b0;
      link.connect <= 1'b0;
      link.write   <= 1'b0;
      link.ch_data <= '0;
      link.ch_par  <= 1'b0;
      done_o       <= 1'b0;
      done_reject_o <= 1'b0;
      rd_data_o    <= '0;
      rd_par_err_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      case (st_ff)
        CS_IDLE: begin
          cnt_ff <= '0;
          if (req_valid_i && req_ready_o) begin
            link.strobe  <= 1'b1;
            link.connect <= req_connect_i;
            link.write   <= req_write_i | req_connect_i;
            link.ch_data <= req_data_i;
            link.ch_par  <= ~^req_data_i;
            st_ff        <= CS_WAIT;
          end
        end
        CS_WAIT: begin
          cnt_ff <= '0;
          if (link.reply || link.reject) begin
            st_ff <= CS_DESKEW;
          end
        end
        CS_DESKEW: begin
          cnt_ff <= cnt_ff + 1'b1;
          if (cnt_ff >= dsk - 1'b1) begin
            cnt_ff <= '0;
            st_ff  <= CS_SAMPLE;
          end
        end
        CS_SAMPLE: begin
          cnt_ff <= cnt_ff + 1'b1;
          if (cnt_ff >= llw_pkg::CNT_W'(llw_pkg::SAMPLE_CYC - 1)) begin
            rej_ff <= link.reject;
            if (!link.write) begin
              rd_data_o    <= link.dev_data;
              rd_par_err_o <= (~^link.dev_data) != link.dev_par;
            end
            link.strobe  <= 1'b0;
            link.connect <= 1'b0;
            st_ff        <= CS_FALL;
          end
        end
        default: begin
          if (!link.reply && !link.reject) begin
            done_o        <= 1'b1;
            done_reject_o <= rej_ff;
            st_ff         <= CS_IDLE;
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ### tb/llw_chk.sv
// llw_chk: timing checks on the link between channel and peripheral
`timescale 1ns/1ps
`default_nettype none
module llw_chk (
  input  wire logic                       core_clk_i,
  input  wire logic                       resetn_i,
  input  wire logic                       long_cable_i,
  input  wire logic                       strobe,
  input  wire logic                       connect,
  input  wire logic                       write,
  input  wire logic [llw_pkg::DATA_W-1:0] dev_data,
  input  wire logic                       reply,
  input  wire logic                       reject
);
  localparam int CONN_MIN  = llw_pkg::CONNECT_CYC;
  localparam int WR_SHORT  = llw_pkg::DESKEW_CYC + llw_pkg::PARITY_CYC;
  localparam int WR_LONG   = llw_pkg::DATA_DESKEW_LONG_CYC
                             + llw_pkg::PARITY_CYC + llw_pkg::EXTRA_LONG_CYC;
  localparam int RD_SHORT  = llw_pkg::READ_REPLY_CYC;
  localparam int RD_LONG   = llw_pkg::READ_REPLY_LONG_CYC;
  localparam int SMP_SHORT = llw_pkg::DESKEW_CYC + llw_pkg::SAMPLE_CYC;
  localparam int SMP_LONG  = llw_pkg::DESKEW_LONG_CYC + llw_pkg::SAMPLE_CYC;
  logic                       answer;
  logic [9:0]                 ans_cnt;
  logic [9:0]                 hi_cnt;
  logic [9:0]                 con_cnt;
  logic [9:0]                 age_cnt;
  logic [llw_pkg::DATA_W-1:0] data_q;
  assign answer = reply | reject;
  ////////////////////////////////////////////////////////////////////////////
  // cycles since strobe rose
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i || !strobe) hi_cnt <= '0;
    else if (hi_cnt != '1) hi_cnt <= hi_cnt + 10'h001;
  end
  // cycles since connect rose
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i || !connect) con_cnt <= '0;
    else if (con_cnt != '1) con_cnt <= con_cnt + 10'h001;
  end
  // cycles since reply or refusal rose
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i || !answer) ans_cnt <= '0;
    else if (ans_cnt != '1) ans_cnt <= ans_cnt + 10'h001;
  end
  // cycles the returned word has stood unchanged
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      data_q  <= '0;
      age_cnt <= '0;
    end else begin
      data_q <= dev_data;
      if (dev_data != data_q) age_cnt <= 10'h001;
      else if (age_cnt != '1) age_cnt <= age_cnt + 10'h001;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  sequence s_quiet8;
    !answer [*8];
  endsequence
  sequence s_new_write;
    $rose(strobe) && write && !connect;
  endsequence
  a_connect_wait: assert property (
    $rose(answer) && connect |-> con_cnt >= CONN_MIN)
    else $error("answer came too soon after connect");
  a_write_delay: assert property (
    $rose(answer) && write && !connect
    |-> hi_cnt >= (long_cable_i ? WR_LONG : WR_SHORT))
    else $error("write answered before its delay");
  a_write_quiet: assert property (
    s_new_write |-> s_quiet8 ##1 !answer)
    else $error("write answered within the sample floor");
  a_write_answer: assert property (
    s_new_write |-> ##[1:200] answer)
    else $error("write got neither reply nor refusal");
  a_read_hold: assert property (
    $rose(reply) && !write && !connect
    |-> age_cnt >= (long_cable_i ? RD_LONG : RD_SHORT))
    else $error("read reply came too soon after data");
  a_reply_keep: assert property (
    answer && strobe |=> answer)
    else $error("reply dropped while strobe high");
  a_reply_release: assert property (
    $fell(strobe) && answer |-> ##[1:3] !answer)
    else $error("reply kept after strobe fell");
  a_strobe_fresh: assert property (
    $rose(strobe) |-> !answer)
    else $error("strobe raised before reply fell");
  a_strobe_drop: assert property (
    $rose(answer) |-> ##[1:60] !strobe)
    else $error("strobe not withdrawn after reply");
  a_chan_deskew: assert property (
    $fell(strobe) && answer
    |-> ans_cnt >= (long_cable_i ? SMP_LONG : SMP_SHORT))
    else $error("channel sampled before its deskew");
endmodule
`default_nettype wire

// ### tb/long_line_word_handshake_test.sv
// long_line_word_handshake_test: channel and peripheral joined end to end
`timescale 1ns/1ps
`default_nettype none
module long_line_word_handshake_test;
  logic                       core_clk_i   = 1'b0;
  logic                       resetn_i     = 1'b0;
  logic                       long_cable_i = 1'b0;
  logic                       req_valid_i, req_write_i, req_connect_i;
  logic                       req_ready_o, done_o, done_reject_o;
  logic                       rd_par_err_o, selected_o, par_err_o;
  logic                       rx_valid_o, rx_ready_i, tx_valid_i, tx_ready_o;
  logic [llw_pkg::DATA_W-1:0] req_data_i, rd_data_o, rx_data_o, tx_data_i;
  int                         fails    = 0;
  int                         n_checks = 0;
  int                         n_par_err = 0;
  llw_link_if link ();
  always #5 core_clk_i = ~core_clk_i;
  // parity error pulses, looked at mid-cycle
  always @(negedge core_clk_i) begin
    if (par_err_o === 1'b1) n_par_err++;
  end
  llw_chan i_llw_chan (.core_clk_i, .resetn_i, .long_cable_i, .link,
    .req_valid_i, .req_ready_o, .req_write_i, .req_connect_i, .req_data_i,
    .done_o, .done_reject_o, .rd_data_o, .rd_par_err_o);
  llw_dev i_llw_dev (.core_clk_i, .resetn_i, .long_cable_i, .link,
    .selected_o, .rx_valid_o, .rx_ready_i, .rx_data_o, .tx_valid_i,
    .tx_ready_o, .tx_data_i, .par_err_o);
  llw_chk i_llw_chk (.core_clk_i, .resetn_i, .long_cable_i,
    .strobe(link.strobe), .connect(link.connect), .write(link.write),
    .dev_data(link.dev_data), .reply(link.reply), .reject(link.reject));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // one request, held until taken, then waits for completion
  task automatic xfer(input logic wr, input logic con,
                      input logic [llw_pkg::DATA_W-1:0] d);
    int i;
    req_valid_i = 1'b1;
    req_write_i = wr;
    req_connect_i = con;
    req_data_i = d;
    for (i = 0; i < 400 && req_ready_o !== 1'b1; i++) @(negedge core_clk_i);
    if (req_ready_o !== 1'b1) begin
      fails++;
      wrap_up();
    end
    @(negedge core_clk_i);
    req_valid_i = 1'b0;
    for (i = 0; i < 1000 && done_o !== 1'b1; i++) @(negedge core_clk_i);
    if (done_o !== 1'b1) begin
      fails++;
      wrap_up();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (100000) @(posedge core_clk_i);
    fails++;
    wrap_up();
  end
  initial begin
    int k;
    int n;
    req_valid_i = 1'b0;
    req_write_i = 1'b0;
    req_connect_i = 1'b0;
    req_data_i = '0;
    rx_ready_i = 1'b0;
    tx_valid_i = 1'b0;
    tx_data_i = '0;
    repeat (3) @(negedge core_clk_i);
    resetn_i = 1'b1;
    chk(16'(selected_o), 16'h0000);
    xfer(1'b1, 1'b1, 12'h001);
    chk(16'(selected_o), 16'h0001);
    // fill the receive buffer while the user side stalls
    for (k = 0; k < 16; k++) begin
      long_cable_i = k[0];
      xfer(1'b1, 1'b0, 12'ha50 ^ k[11:0]);
      chk(16'(done_reject_o), 16'h0000);
    end
    chk(16'(n_par_err), 16'h0000);
    for (k = 0; k < 16; k++) begin
      chk(16'(rx_valid_o), 16'h0001);
      chk(16'(rx_data_o), 16'(12'ha50 ^ k[11:0]));
      rx_ready_i = 1'b1;
      @(negedge core_clk_i);
      rx_ready_i = 1'b0;
    end
    chk(16'(rx_valid_o), 16'h0000);
    // fill the send buffer until it refuses
    n = 0;
    while (tx_ready_o === 1'b1 && n < 20) begin
      tx_valid_i = 1'b1;
      tx_data_i = 12'h3c0 + n[11:0];
      @(negedge core_clk_i);
      n++;
    end
    tx_valid_i = 1'b0;
    chk(16'(n), 16'h0010);
    for (k = 0; k < n; k++) begin
      long_cable_i = k[0];
      xfer(1'b0, 1'b0, '0);
      chk(16'(rd_data_o), 16'(12'h3c0 + k[11:0]));
      chk(16'(rd_par_err_o), 16'h0000);
    end
    chk(16'(tx_ready_o), 16'h0001);
    wrap_up();
  end
endmodule
`default_nettype wire
